// File: inc/counter_pkg.sv
package counter_pkg;

  // variant selection
  typedef enum logic [2:0] {
    variant_up_clear  = 3'b001,
    variant_bidir     = 3'b010,
    variant_up_sync   = 3'b100
  } variant_type;

  localparam int unsigned count_width_narrow = 8;
  localparam int unsigned count_width_wide   = 16;
  localparam int unsigned count_width_dflt   = count_width_narrow;

  // axi4-lite register byte offsets
  localparam logic [7:0] reg_ctrl_ofs    = 8'h00;
  localparam logic [7:0] reg_preset_ofs  = 8'h04;
  localparam logic [7:0] reg_count_ofs   = 8'h08;
  localparam logic [7:0] reg_status_ofs  = 8'h0c;
  localparam logic [7:0] reg_irq_sts_ofs = 8'h10;
  localparam logic [7:0] reg_irq_en_ofs  = 8'h14;
  localparam logic [7:0] reg_irq_clr_ofs = 8'h18;

  // ctrl field positions
  localparam int unsigned ctrl_gate_bit  = 0;
  localparam int unsigned ctrl_dir_bit   = 1;
  localparam int unsigned ctrl_load_bit  = 2;
  localparam int unsigned ctrl_wipe_bit  = 3;
  localparam int unsigned ctrl_sel_bit   = 4;

  // status / irq field positions
  localparam int unsigned sts_term_bit   = 0;
  localparam int unsigned sts_chain_bit  = 1;
  localparam int unsigned irq_term_bit   = 0;
  localparam int unsigned irq_wrap_bit   = 1;
  localparam int unsigned irq_width      = 2;

  localparam logic [31:0] ctrl_reset_val = 32'h0000_0000;
  localparam logic [1:0]  resp_okay      = 2'b00;
  localparam logic [1:0]  resp_slverr    = 2'b10;

endpackage : counter_pkg

// File: logic/counter_core.sv
`timescale 1ns/10ps
`default_nettype none
module counter_core
  import counter_pkg::*;
#(
  parameter int unsigned       width   = count_width_dflt,
  parameter variant_type       variant = variant_up_clear
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             async_wipe,
  input  wire logic             sync_wipe,
  input  wire logic             preset_strobe,
  input  wire logic [width-1:0] preset_value,
  input  wire logic             count_gate,
  input  wire logic             count_dir,
  output logic      [width-1:0] count_value,
  output logic                  terminal_flag,
  output logic                  chain_out,
  output logic                  wrap_event
);

  typedef struct packed {
    logic [width-1:0] count;
  } core_state_type;

  core_state_type state_ff;
  core_state_type nxt_state;
  logic           all_ones;
  logic           all_zero;
  logic           up;

  always_comb begin
    up = (variant == variant_bidir) ? count_dir : 1'b1;
  end

  always_comb begin
    nxt_state = state_ff;
    if (sync_wipe && variant == variant_up_sync) begin
      nxt_state.count = '0;
    end else if (preset_strobe && variant != variant_up_sync) begin
      nxt_state.count = preset_value;
    end else if (count_gate) begin
      if (up) begin
        nxt_state.count = state_ff.count + 1'b1;
      end else begin
        nxt_state.count = state_ff.count - 1'b1;
      end
    end
  end

  always_ff @(posedge aclk or posedge async_wipe) begin
    if (async_wipe) begin
      state_ff <= '0;
    end else if (!aresetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    all_ones    = &state_ff.count;
    all_zero    = ~|state_ff.count;
    count_value = state_ff.count;
    case (variant)
      variant_bidir:   terminal_flag = (all_ones & count_dir) | (all_zero & ~count_dir);
      variant_up_sync: terminal_flag = all_ones & count_gate;
      default:         terminal_flag = all_ones;
    endcase
    if (async_wipe) begin
      terminal_flag = 1'b0;
    end
    chain_out  = terminal_flag & count_gate;
    wrap_event = chain_out & ~preset_strobe & ~sync_wipe;
  end

endmodule : counter_core
`default_nettype wire

// File: logic/cascadable_binary_counter.sv
// Overview of operation
// - async wipe zeroes count and terminal flag immediately, over everything
// - preset strobe high at clock edge loads preset value (the sync variant ignores preset strobe and never loads)
// - load works regardless of count gate and beats counting
// - up-only counter increments on each edge with gate high
// - gate low without load or wipe holds count; flag still follows direction (bidirectional) and gate (sync variant)
// - up-only clear variant: flag high when all count bits one
// - bidirectional: gate high and direction low decrements
// - bidirectional: gate high and direction high increments
// - bidirectional: flag high when direction high and all ones
// - bidirectional: flag high when direction low and all zeros
// - chain out equals terminal flag AND count gate
// - sync variant: sync wipe zeroes count and flag at next edge
// - sync variant: flag high only when all ones and gate high
// - width selectable 8 or 16, preset and count buses match
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module cascadable_binary_counter
  import counter_pkg::*;
#(
  parameter int unsigned width   = count_width_dflt,
  parameter variant_type variant = variant_up_clear
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             async_wipe,
  input  wire logic             sync_wipe,
  input  wire logic             preset_strobe,
  input  wire logic [width-1:0] preset_value,
  input  wire logic             count_gate,
  input  wire logic             count_dir,
  output logic      [width-1:0] count_value,
  output logic                  terminal_flag,
  output logic                  chain_out,
  output logic                  irq,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic      [1:0]       s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic      [31:0]      s_axi_rdata,
  output logic      [1:0]       s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);

  typedef struct packed {
    logic                 aw_held;
    logic [7:0]           aw_addr;
    logic                 w_held;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic [4:0]           ctrl;
    logic [width-1:0]     preset;
    logic [irq_width-1:0] irq_sts;
    logic [irq_width-1:0] irq_en;
    logic                 term_prev;
  } top_state_type;

  top_state_type state_ff;
  top_state_type nxt_state;
  logic          gate_int;
  logic          dir_int;
  logic          load_int;
  logic          swipe_int;
  logic          wipe_int;
  logic [width-1:0] preset_int;
  logic          wrap_event;
  logic          wr_fire;
  logic          sw_sel;
  logic [irq_width-1:0] irq_set;
  logic [irq_width-1:0] irq_clr;

  // apply byte strobes to a stored word
  function automatic logic [31:0] merge_word(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_word

  function automatic logic addr_known(input logic [7:0] a);
    return (a == reg_ctrl_ofs) || (a == reg_preset_ofs) || (a == reg_count_ofs) ||
           (a == reg_status_ofs) || (a == reg_irq_sts_ofs) || (a == reg_irq_en_ofs) ||
           (a == reg_irq_clr_ofs);
  endfunction : addr_known

  // software may drive gate and direction in place of the pins when sel is set
  always_comb begin
    sw_sel     = state_ff.ctrl[ctrl_sel_bit];
    gate_int   = sw_sel ? state_ff.ctrl[ctrl_gate_bit] : count_gate;
    dir_int    = sw_sel ? state_ff.ctrl[ctrl_dir_bit]  : count_dir;
    load_int   = preset_strobe | (wr_fire && state_ff.aw_addr == reg_ctrl_ofs &&
                 state_ff.w_strb[0] && state_ff.w_data[ctrl_load_bit]);
    swipe_int  = sync_wipe | state_ff.ctrl[ctrl_wipe_bit];
    wipe_int   = async_wipe;
    preset_int = preset_strobe ? preset_value : state_ff.preset;
  end

  counter_core #(
    .width   (width),
    .variant (variant)
  ) u_core (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .async_wipe    (wipe_int),
    .sync_wipe     (swipe_int),
    .preset_strobe (load_int),
    .preset_value  (preset_int),
    .count_gate    (gate_int),
    .count_dir     (dir_int),
    .count_value   (count_value),
    .terminal_flag (terminal_flag),
    .chain_out     (chain_out),
    .wrap_event    (wrap_event)
  );

  assign s_axi_awready = ~state_ff.aw_held & ~state_ff.bvalid;
  assign s_axi_wready  = ~state_ff.w_held & ~state_ff.bvalid;
  assign s_axi_arready = ~state_ff.rvalid;
  assign s_axi_bvalid  = state_ff.bvalid;
  assign s_axi_bresp   = state_ff.bresp;
  assign s_axi_rvalid  = state_ff.rvalid;
  assign s_axi_rresp   = state_ff.rresp;
  assign s_axi_rdata   = state_ff.rdata;
  assign irq           = |(state_ff.irq_sts & state_ff.irq_en);
  assign wr_fire       = state_ff.aw_held & state_ff.w_held & ~state_ff.bvalid;

  always_comb begin
    logic [31:0] w;
    w         = '0;
    nxt_state = state_ff;
    irq_set   = '0;
    irq_clr   = '0;
    irq_set[irq_term_bit] = terminal_flag & ~state_ff.term_prev;
    irq_set[irq_wrap_bit] = wrap_event;
    nxt_state.term_prev   = terminal_flag;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_state.aw_held = 1'b1;
      nxt_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_state.w_held = 1'b1;
      nxt_state.w_data = s_axi_wdata;
      nxt_state.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_state.aw_held = 1'b0;
      nxt_state.w_held  = 1'b0;
      nxt_state.bvalid  = 1'b1;
      nxt_state.bresp   = addr_known(state_ff.aw_addr) ? resp_okay : resp_slverr;
      if (state_ff.aw_addr == reg_ctrl_ofs) begin
        w = merge_word({27'h0, state_ff.ctrl}, state_ff.w_data, state_ff.w_strb);
        nxt_state.ctrl = w[4:0];
        nxt_state.ctrl[ctrl_load_bit] = 1'b0;
      end else if (state_ff.aw_addr == reg_preset_ofs) begin
        w = merge_word(32'(state_ff.preset), state_ff.w_data, state_ff.w_strb);
        nxt_state.preset = w[width-1:0];
      end else if (state_ff.aw_addr == reg_irq_en_ofs) begin
        w = merge_word(32'(state_ff.irq_en), state_ff.w_data, state_ff.w_strb);
        nxt_state.irq_en = w[irq_width-1:0];
      end else if (state_ff.aw_addr == reg_irq_clr_ofs && state_ff.w_strb[0]) begin
        irq_clr = state_ff.w_data[irq_width-1:0];
      end
    end
    // a new event wins over a simultaneous clear
    nxt_state.irq_sts = (state_ff.irq_sts & ~irq_clr) | irq_set;
    if (state_ff.bvalid && s_axi_bready) begin
      nxt_state.bvalid = 1'b0;
    end
    if (state_ff.rvalid && s_axi_rready) begin
      nxt_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp  = addr_known(s_axi_araddr) ? resp_okay : resp_slverr;
      if (s_axi_araddr == reg_ctrl_ofs) begin
        nxt_state.rdata = {27'h0, state_ff.ctrl};
      end else if (s_axi_araddr == reg_preset_ofs) begin
        nxt_state.rdata = 32'(state_ff.preset);
      end else if (s_axi_araddr == reg_count_ofs) begin
        nxt_state.rdata = 32'(count_value);
      end else if (s_axi_araddr == reg_status_ofs) begin
        nxt_state.rdata = {30'h0, chain_out, terminal_flag};
      end else if (s_axi_araddr == reg_irq_sts_ofs) begin
        nxt_state.rdata = 32'(state_ff.irq_sts);
      end else if (s_axi_araddr == reg_irq_en_ofs) begin
        nxt_state.rdata = 32'(state_ff.irq_en);
      end else begin
        nxt_state.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff      <= '0;
      state_ff.ctrl <= ctrl_reset_val[4:0];
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule : cascadable_binary_counter
`default_nettype wire

// File: bench/next_stage.sv
`timescale 1ns/10ps
`default_nettype none
module next_stage (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       async_wipe,
  input  wire logic       preset_strobe,
  input  wire logic [7:0] preset_value,
  input  wire logic       count_gate,
  input  wire logic       count_dir,
  output logic      [7:0] count_value
);
  always_ff @(posedge aclk or posedge async_wipe) begin
    if (async_wipe)
      count_value <= 8'h00;
    else if (!aresetn)
      count_value <= 8'h00;
    else if (preset_strobe)
      count_value <= preset_value;
    else if (count_gate)
      count_value <= count_dir ? count_value + 8'h01 : count_value - 8'h01;
  end
endmodule : next_stage
`default_nettype wire

// File: bench/counter_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module counter_checker #(
  parameter int unsigned width = 8
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             async_wipe,
  input wire logic             preset_strobe,
  input wire logic [width-1:0] preset_value,
  input wire logic             count_gate,
  input wire logic             count_dir,
  input wire logic [width-1:0] count_value,
  input wire logic             terminal_flag,
  input wire logic             chain_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_load;
    preset_strobe && !async_wipe;
  endsequence
  sequence s_step(d);
    count_gate && !preset_strobe && !async_wipe && count_dir == d;
  endsequence
  property p_wipe;
    async_wipe |-> count_value == '0 && !terminal_flag;
  endproperty
  property p_load;
    s_load |=> async_wipe || count_value == $past(preset_value);
  endproperty
  property p_up;
    s_step(1'b1) |=> async_wipe || count_value == $past(count_value) + 1'b1;
  endproperty
  property p_down;
    s_step(1'b0) |=> async_wipe || count_value == $past(count_value) - 1'b1;
  endproperty
  property p_hold;
    !count_gate && !preset_strobe && !async_wipe |=> async_wipe || $stable(count_value);
  endproperty
  property p_tc_up;
    count_dir && !async_wipe |-> terminal_flag == (&count_value);
  endproperty
  property p_tc_dn;
    !count_dir && !async_wipe |-> terminal_flag == (count_value == '0);
  endproperty
  property p_chain;
    chain_out == (terminal_flag && count_gate);
  endproperty
  a_wipe: assert property (p_wipe) else $error("wipe left count or flag set");
  a_load: assert property (p_load) else $error("preset not captured");
  a_up: assert property (p_up) else $error("up step wrong");
  a_down: assert property (p_down) else $error("down step wrong");
  a_hold: assert property (p_hold) else $error("count moved while gate low");
  a_tc_up: assert property (p_tc_up) else $error("flag wrong counting up");
  a_tc_dn: assert property (p_tc_dn) else $error("flag wrong counting down");
  a_chain: assert property (p_chain) else $error("chain out wrong");
endmodule : counter_checker
bind cascadable_binary_counter counter_checker #(.width(width)) counter_checker_inst (.aclk(aclk),
  .aresetn(aresetn), .async_wipe(async_wipe), .preset_strobe(preset_strobe), .preset_value(preset_value),
  .count_gate(count_gate), .count_dir(count_dir), .count_value(count_value), .terminal_flag(terminal_flag),
  .chain_out(chain_out));
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench import counter_pkg::*;;
  logic        aclk = 1'b0, aresetn = 1'b0, async_wipe = 1'b0, preset_strobe = 1'b0, count_gate = 1'b0;
  logic        count_dir = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        terminal_flag, chain_out, irq, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  preset_value = 8'h00, awaddr = 8'h00, araddr = 8'h00, count_value, hi_count;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  int          miscompares = 0, samples_checked = 0, m = 0;
  always #10 aclk = ~aclk;
  cascadable_binary_counter #(.width(8), .variant(variant_bidir)) cascadable_binary_counter_inst (
    .aclk(aclk), .aresetn(aresetn), .async_wipe(async_wipe), .sync_wipe(1'b0), .preset_strobe(preset_strobe),
    .preset_value(preset_value), .count_gate(count_gate), .count_dir(count_dir), .count_value(count_value),
    .terminal_flag(terminal_flag), .chain_out(chain_out), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // upper stage fed by chain out, sharing clock, load, wipe and direction
  next_stage next_stage_inst (.aclk(aclk), .aresetn(aresetn), .async_wipe(async_wipe),
    .preset_strobe(preset_strobe), .preset_value(preset_value), .count_gate(chain_out),
    .count_dir(count_dir), .count_value(hi_count));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // drive one cycle of counter inputs, check the state left by the previous edge
  task automatic cyc(input logic l, input logic g, input logic d, input logic [7:0] p);
    logic t;
    @(posedge aclk);
    preset_strobe <= l;
    count_gate <= g;
    count_dir <= d;
    preset_value <= p;
    #1;
    t = d ? (m[7:0] == 8'hff) : (m[7:0] == 8'h00);
    chk({hi_count, count_value}, m[15:0]);
    chk({15'h0, terminal_flag}, {15'h0, t});
    chk({15'h0, chain_out}, {15'h0, t & g});
    m = l ? {p, p} : (g ? ((d ? m + 1 : m - 1) & 16'hffff) : m);
  endtask : cyc
  task automatic wipe();
    @(posedge aclk);
    async_wipe <= 1'b1;
    count_gate <= 1'b0;
    preset_strobe <= 1'b0;
    #5;
    chk({hi_count, count_value}, 16'h0);
    chk({15'h0, terminal_flag}, 16'h0);
    @(posedge aclk);
    async_wipe <= 1'b0;
    m = 0;
  endtask : wipe
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    logic ah, rh;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge aclk);
      ah = arvalid & arready;
      rh = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axr
  initial begin
    rd = $urandom(32'hb72a);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(reg_ctrl_ofs);
    chk(rd[15:0], ctrl_reset_val[15:0]);
    chk({14'h0, rs}, {14'h0, resp_okay});
    $display("test reset done");
    for (int i = 0; i < 400; i++) begin
      if ($urandom % 40 == 0) wipe();
      else cyc($urandom % 6 == 0, $urandom % 4 != 0, i[6], ($urandom % 2) ? 8'hfe : 8'h01);
    end
    $display("test counting done");
    cyc(1'b1, 1'b0, 1'b1, 8'h01);
    cyc(1'b0, 1'b0, 1'b1, 8'h00);
    axw(reg_irq_en_ofs, 32'h0);
    axw(reg_irq_clr_ofs, 32'h3);
    chk({14'h0, rs}, {14'h0, resp_okay});
    cyc(1'b1, 1'b0, 1'b1, 8'hff);
    cyc(1'b0, 1'b1, 1'b1, 8'h00);
    cyc(1'b0, 1'b0, 1'b1, 8'h00);
    axr(reg_irq_sts_ofs);
    chk({15'h0, rd[1]}, 16'h1);
    chk({15'h0, irq}, 16'h0);
    axw(reg_irq_en_ofs, 32'h2);
    @(posedge aclk);
    #1 chk({15'h0, irq}, 16'h1);
    axw(reg_irq_clr_ofs, 32'h3);
    @(posedge aclk);
    #1 chk({15'h0, irq}, 16'h0);
    axr(reg_irq_sts_ofs);
    chk(rd[15:0], 16'h0);
    axr(8'h20);
    chk({14'h0, rs}, {14'h0, resp_slverr});
    chk(rd[15:0], 16'h0);
    axr(reg_count_ofs);
    chk(rd[15:0], {8'h00, m[7:0]});
    $display("test registers done");
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    complete_run();
  end
endmodule : testbench
`default_nettype wire
